// ---- cia_pkg.sv ----
package cia_pkg;

  // ****************************************************************
  // Register selects, fields and reset values
  // ****************************************************************
  localparam logic       REG_SEL_SCS     = 1'h0;
  localparam logic       REG_SEL_PSW     = 1'h1;
  localparam logic [7:0] SCS_RESET_VAL   = 8'h00;
  localparam logic [7:0] PSW_RESET_VAL   = 8'h02;
  localparam int         PSW_IE_BIT      = 7;
  localparam int         PSW_ISP_BIT     = 1;
  localparam int         SCS_SEL_LSB     = 0;
  localparam int         SCS_SEL_MSB     = 1;

  // ****************************************************************
  // Sampling clock divisions
  // ****************************************************************
  localparam logic [1:0] SCS_SEL_CPU     = 2'h0;
  localparam logic [1:0] SCS_SEL_DIV5    = 2'h1;
  localparam logic [1:0] SCS_SEL_DIV6    = 2'h2;
  localparam logic [2:0] CPU_DIV_MAX     = 3'h4;
  localparam logic [2:0] PERI_DIV5       = 3'h5;
  localparam logic [2:0] PERI_DIV6       = 3'h6;
  localparam logic [2:0] PERI_DIV7       = 3'h7;
  localparam int         PRESC_W         = 8;

  // ****************************************************************
  // Vectors and acknowledge timing
  // ****************************************************************
  localparam logic [15:0] NMI_VEC        = 16'h0004;
  localparam logic [15:0] MASK_VEC_BASE  = 16'h0006;
  localparam logic [15:0] BRK_VEC        = 16'h003E;
  localparam int          ACK_MIN_HI_CLK = 7;
  localparam int          ACK_MAX_HI_CLK = 32;
  localparam int          ACK_MIN_LO_CLK = 8;
  localparam int          ACK_MAX_LO_CLK = 33;
  localparam int          LO_EXTRA_CLK   = ACK_MIN_LO_CLK - ACK_MIN_HI_CLK;
  localparam int          FILT_SRC       = 0;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_WAIT = 3'b001,
    SEQ_PSW  = 3'b010,
    SEQ_PC   = 3'b011
  } cia_seq_e;

  typedef enum logic [1:0] {
    KIND_NMI  = 2'b00,
    KIND_MASK = 2'b01,
    KIND_BRK  = 2'b10
  } cia_kind_e;

endpackage

// ---- cia_filt_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface cia_filt_if;
  logic sample_tick;
  logic pin_level;
  logic req_set;

  modport filt (input sample_tick, input pin_level, output req_set);
  modport main (output sample_tick, output pin_level, input req_set);
endinterface
`default_nettype wire

// ---- cia_noise_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module cia_noise_filter
  import cia_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  cia_filt_if.filt  fif
);

  typedef struct packed {
    logic prev;
    logic older;
    logic req;
  } cia_filt_s;

  cia_filt_s state_ff;
  cia_filt_s nxt_state;

  // ****************************************************************
  // Two-sample qualifier
  // ****************************************************************
  // A level is only sampled on the tick, so a pulse that falls between
  // two ticks is never seen and raises nothing.
  always_comb begin
    nxt_state     = state_ff;
    nxt_state.req = 1'b0;
    if (fif.sample_tick) begin
      nxt_state.prev  = fif.pin_level;
      nxt_state.older = state_ff.prev;
      nxt_state.req   = fif.pin_level & state_ff.prev & ~state_ff.older;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign fif.req_set = state_ff.req;

  two_samples_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_ff.req |-> state_ff.prev && state_ff.older)
    else $error("request set without two active samples");

endmodule
`default_nettype wire

// ---- cia_ack_unit.sv ----
//Function
//- Sampling clock select register is a whole-byte register reset to zero.
//- Sample clock is CPU clock or peripheral division; CPU choice stops in halt.
//- Pin request sets only after two consecutive active samples.
//- A pulse shorter than a sampling period leaves the request clear.
//- Status word is byte and bit writable and resets to 0x02.
//- Any acknowledge or break pushes status word and clears global enable.
//- Maskable acknowledge copies the request priority into in-service priority.
//- Returns and pop restore status word; push-status stores it.
//- Non-maskable request ignores enable, priority, and outranks all but break.
//- Non-maskable acknowledge pushes status then PC, clears both flags, loads vector.
//- New non-maskable request waits for return plus one main instruction.
//- Several non-maskable requests during service collapse into one.
//- Maskable request eligible only with flag set and mask clear.
//- Needs global enable; low priority blocked while in-service priority clear.
//- High-priority latency is 7 to 32 CPU clocks.
//- Low-priority latency is 8 to 33 CPU clocks.
//- Simultaneous requests: high programmable priority first, ties by fixed order.
//- Unacknowledged requests stay pending until their conditions hold.
//- Maskable acknowledge pushes status then PC, clears enable, loads its vector.
//- Break cannot be disabled; pushes status, PC, clears enable, fixed vector.
//- Acknowledge clears the request flag before the handler runs.
//- Priority flag 0 is high priority, 1 is low priority.
`timescale 1ns/1ps
`default_nettype none
module cia_ack_unit
  import cia_pkg::*;
#(
  parameter int NUM_IRQ = 8
)(
  input  wire logic               CLOCK_IN,
  input  wire logic               RST_N_IN,
  input  wire logic               FILT_PIN_IN,
  input  wire logic [2:0]         CPU_DIV_N_IN,
  input  wire logic               HALT_IN,
  input  wire logic [NUM_IRQ-1:0] IRQ_SET_IN,
  input  wire logic [NUM_IRQ-1:0] MASK_IN,
  input  wire logic [NUM_IRQ-1:0] PRIO_IN,
  input  wire logic               NMI_IN,
  input  wire logic               BOUNDARY_IN,
  input  wire logic               HOLD_IN,
  input  wire logic               BRK_IN,
  input  wire logic               INTERRUPT_RETURN_INSTR_IN,
  input  wire logic               BREAK_RETURN_INSTR_IN,
  input  wire logic               POP_PSW_IN,
  input  wire logic               PUSH_PSW_IN,
  input  wire logic               EI_IN,
  input  wire logic               DI_IN,
  input  wire logic [7:0]         STACK_DATA_IN,
  input  wire logic               REG_WR_IN,
  input  wire logic               REG_SEL_IN,
  input  wire logic [7:0]         REG_WDATA_IN,
  input  wire logic               BIT_WR_IN,
  input  wire logic [2:0]         BIT_IDX_IN,
  input  wire logic               BIT_VAL_IN,
  output var  logic [7:0]         SCS_OUT,
  output var  logic [7:0]         PSW_OUT,
  output var  logic [NUM_IRQ-1:0] IRQ_FLAG_OUT,
  output var  logic               BUSY_OUT,
  output var  logic               ACK_OUT,
  output var  logic [1:0]         ACK_KIND_OUT,
  output var  logic               STACK_PUSH_OUT,
  output var  logic [7:0]         STACK_DATA_OUT,
  output var  logic               PC_PUSH_OUT,
  output var  logic               VEC_LOAD_OUT,
  output var  logic [15:0]        VEC_ADDR_OUT
);

  localparam int IW = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

  typedef struct packed {
    logic [7:0]         sampling_clock_select_reg;
    logic [7:0]         program_status_word;
    logic [PRESC_W-1:0] presc;
    logic               tick;
    logic [NUM_IRQ-1:0] flag;
    logic               nmi_pend;
    logic               nmi_act;
    cia_seq_e           seq;
    cia_kind_e          kind;
    logic               ack_prio;
    logic               busy;
    logic               ack;
    logic               push;
    logic [7:0]         saved;
    logic               pc_push;
    logic               vec_load;
    logic [15:0]        vec;
  } cia_main_s;

  cia_main_s  state_ff;
  cia_main_s  nxt_state;
  cia_filt_if fif ();

  // ****************************************************************
  // Fixed-order pick
  // ****************************************************************
  // Returns a found bit over the index of the lowest set candidate, so
  // the lowest source number holds the higher fixed priority.
  function automatic logic [IW:0] pick(input logic [NUM_IRQ-1:0] cand);
    logic [IW:0] res;
    res = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (cand[i]) begin
        res = {1'b1, IW'(i)};
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // Noise filter
  // ****************************************************************
  cia_noise_filter u_filt (
    .clk_in   (CLOCK_IN),
    .rst_n_in (RST_N_IN),
    .fif      (fif.filt)
  );

  assign fif.sample_tick = state_ff.tick;
  assign fif.pin_level   = FILT_PIN_IN;

  logic [NUM_IRQ-1:0] cand_hi;
  logic [NUM_IRQ-1:0] cand_lo;
  logic [IW:0]        pick_hi;
  logic [IW:0]        pick_lo;
  logic [NUM_IRQ-1:0] set_vec;
  logic [NUM_IRQ-1:0] clr_vec;
  logic [2:0]         div_sel;
  logic [PRESC_W-1:0] div_mask;
  logic               psw_instr;
  logic               boundary_ok;
  logic               ie;
  logic               in_service_priority;
  logic               take_nmi;
  logic               take_hi;
  logic               take_lo;
  logic [IW-1:0]      idx;
  logic [IW-1:0]      ack_idx;

  // ****************************************************************
  // Acknowledge decision
  // ****************************************************************
  always_comb begin
    // Flag 0 means high priority, 1 means low.
    cand_hi = state_ff.flag & ~MASK_IN & ~PRIO_IN;
    cand_lo = state_ff.flag & ~MASK_IN & PRIO_IN;
    pick_hi = pick(cand_hi);
    pick_lo = pick(cand_lo);
    ie      = state_ff.program_status_word[PSW_IE_BIT];
    in_service_priority     = state_ff.program_status_word[PSW_ISP_BIT];
    // Instructions that touch the status word or the request flags
    // hold acknowledge off for one more instruction.
    psw_instr = HOLD_IN | INTERRUPT_RETURN_INSTR_IN | BREAK_RETURN_INSTR_IN | POP_PSW_IN | PUSH_PSW_IN |
                EI_IN | DI_IN | REG_WR_IN | BIT_WR_IN;
    boundary_ok = BOUNDARY_IN & ~psw_instr &
                  (state_ff.seq == SEQ_IDLE);
    take_nmi = boundary_ok & state_ff.nmi_pend & ~state_ff.nmi_act;
    take_hi  = boundary_ok & ie & ~state_ff.nmi_act & pick_hi[IW];
    take_lo  = boundary_ok & ie & in_service_priority & ~state_ff.nmi_act &
               pick_lo[IW];
    idx      = pick_hi[IW] ? pick_hi[IW-1:0] : pick_lo[IW-1:0];
    ack_idx  = IW'((state_ff.vec - MASK_VEC_BASE) >> 1);
    nxt_state          = state_ff;
    nxt_state.ack      = 1'b0;
    nxt_state.push     = 1'b0;
    nxt_state.pc_push  = 1'b0;
    nxt_state.vec_load = 1'b0;
    set_vec            = IRQ_SET_IN;
    set_vec[FILT_SRC]  = IRQ_SET_IN[FILT_SRC] | fif.req_set;
    clr_vec            = '0;

    // Sampling tick from the free-running prescaler.
    case (state_ff.sampling_clock_select_reg[SCS_SEL_MSB:SCS_SEL_LSB])
      SCS_SEL_CPU:  div_sel = (CPU_DIV_N_IN > CPU_DIV_MAX) ? CPU_DIV_MAX
                                                          : CPU_DIV_N_IN;
      SCS_SEL_DIV5: div_sel = PERI_DIV5;
      SCS_SEL_DIV6: div_sel = PERI_DIV6;
      default:      div_sel = PERI_DIV7;
    endcase
    div_mask        = PRESC_W'((9'h001 << div_sel) - 9'h001);
    nxt_state.presc = state_ff.presc + PRESC_W'(1);
    nxt_state.tick  = ((state_ff.presc & div_mask) == div_mask) &
                      ~(HALT_IN & (state_ff.sampling_clock_select_reg[SCS_SEL_MSB:SCS_SEL_LSB] ==
                                   SCS_SEL_CPU));

    // Register writes from the core.
    if (REG_WR_IN && REG_SEL_IN == REG_SEL_SCS) begin
      nxt_state.sampling_clock_select_reg = REG_WDATA_IN;
    end
    if (REG_WR_IN && REG_SEL_IN == REG_SEL_PSW) begin
      nxt_state.program_status_word = REG_WDATA_IN;
    end
    if (BIT_WR_IN) begin
      nxt_state.program_status_word[BIT_IDX_IN] = BIT_VAL_IN;
    end
    if (EI_IN) begin
      nxt_state.program_status_word[PSW_IE_BIT] = 1'b1;
    end
    if (DI_IN) begin
      nxt_state.program_status_word[PSW_IE_BIT] = 1'b0;
    end
    if (INTERRUPT_RETURN_INSTR_IN || BREAK_RETURN_INSTR_IN || POP_PSW_IN) begin
      nxt_state.program_status_word = STACK_DATA_IN;
    end
    if (INTERRUPT_RETURN_INSTR_IN) begin
      nxt_state.nmi_act = 1'b0;
    end
    if (PUSH_PSW_IN) begin
      nxt_state.push  = 1'b1;
      nxt_state.saved = state_ff.program_status_word;
    end

    // Acknowledge sequencer.
    case (state_ff.seq)
      SEQ_IDLE: begin
        if (BRK_IN) begin
          nxt_state.kind = KIND_BRK;
          nxt_state.vec  = BRK_VEC;
          nxt_state.seq  = SEQ_PSW;
          nxt_state.push = 1'b1;
        end else if (take_nmi) begin
          nxt_state.kind     = KIND_NMI;
          nxt_state.vec      = NMI_VEC;
          nxt_state.nmi_pend = 1'b0;
          nxt_state.nmi_act  = 1'b1;
          nxt_state.seq      = SEQ_PSW;
          nxt_state.push     = 1'b1;
          nxt_state.program_status_word[PSW_ISP_BIT] = 1'b0;
        end else if (take_hi || take_lo) begin
          nxt_state.kind     = KIND_MASK;
          nxt_state.vec      = MASK_VEC_BASE +
                               16'({idx, 1'b0});
          nxt_state.ack_prio = ~take_hi;
          nxt_state.program_status_word[PSW_ISP_BIT] = ~take_hi;
          clr_vec[idx]       = 1'b1;
          // A low-priority grant costs one more clock before stacking.
          nxt_state.seq  = take_hi ? SEQ_PSW : SEQ_WAIT;
          nxt_state.push = take_hi;
        end
        if (BRK_IN || take_nmi || take_hi || take_lo) begin
          nxt_state.ack   = 1'b1;
          nxt_state.saved = state_ff.program_status_word;
          nxt_state.program_status_word[PSW_IE_BIT] = 1'b0;
        end
      end
      SEQ_WAIT: begin
        nxt_state.seq  = SEQ_PSW;
        nxt_state.push = 1'b1;
      end
      SEQ_PSW: begin
        nxt_state.seq     = SEQ_PC;
        nxt_state.pc_push = 1'b1;
      end
      default: begin
        nxt_state.seq      = SEQ_IDLE;
        nxt_state.vec_load = 1'b1;
      end
    endcase
    nxt_state.busy = (nxt_state.seq != SEQ_IDLE);

    // A request raised in its clearing cycle survives; repeated NMIs
    // simply keep the one pending bit set.
    nxt_state.flag = (state_ff.flag & ~clr_vec) | set_vec;
    if (NMI_IN) begin
      nxt_state.nmi_pend = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      state_ff       <= '0;
      state_ff.sampling_clock_select_reg   <= SCS_RESET_VAL;
      state_ff.program_status_word   <= PSW_RESET_VAL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign SCS_OUT        = state_ff.sampling_clock_select_reg;
  assign PSW_OUT        = state_ff.program_status_word;
  assign IRQ_FLAG_OUT   = state_ff.flag;
  assign BUSY_OUT       = state_ff.busy;
  assign ACK_OUT        = state_ff.ack;
  assign ACK_KIND_OUT   = state_ff.kind;
  assign STACK_PUSH_OUT = state_ff.push;
  assign STACK_DATA_OUT = state_ff.saved;
  assign PC_PUSH_OUT    = state_ff.pc_push;
  assign VEC_LOAD_OUT   = state_ff.vec_load;
  assign VEC_ADDR_OUT   = state_ff.vec;

  // ****************************************************************
  // Checks
  // ****************************************************************
  scs_write_a: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    REG_WR_IN && REG_SEL_IN == REG_SEL_SCS |=> SCS_OUT == $past(REG_WDATA_IN))
    else $error("sampling select write not stored");

  psw_reset_a: assert property (
    @(posedge CLOCK_IN)
    !RST_N_IN |=> PSW_OUT == PSW_RESET_VAL && SCS_OUT == SCS_RESET_VAL)
    else $error("status word reset value wrong");

  ack_clears_ie_a: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    ACK_OUT |-> !PSW_OUT[PSW_IE_BIT] &&
                STACK_DATA_OUT == $past(PSW_OUT))
    else $error("acknowledge did not save status or clear enable");

  mask_isp_a: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    ACK_OUT && ACK_KIND_OUT == KIND_MASK |->
      PSW_OUT[PSW_ISP_BIT] == |($past(PRIO_IN) & (NUM_IRQ'(1) << ack_idx)))
    else $error("in-service priority not copied");

  nmi_flags_a: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    ACK_OUT && ACK_KIND_OUT == KIND_NMI |->
      !PSW_OUT[PSW_ISP_BIT] && STACK_PUSH_OUT ##1 PC_PUSH_OUT
      ##1 VEC_LOAD_OUT && VEC_ADDR_OUT == NMI_VEC)
    else $error("non-maskable sequence wrong");

  nmi_hold_a: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    state_ff.nmi_act && !INTERRUPT_RETURN_INSTR_IN |=> !(ACK_OUT && ACK_KIND_OUT == KIND_NMI))
    else $error("nested non-maskable acknowledge");

  ack_enable_a: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    ACK_OUT && ACK_KIND_OUT == KIND_MASK |->
      $past(PSW_OUT[PSW_IE_BIT]) &&
      ($past(PSW_OUT[PSW_ISP_BIT]) || !state_ff.ack_prio))
    else $error("maskable acknowledge while disabled");

  lo_extra_a: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    ACK_OUT && ACK_KIND_OUT == KIND_MASK && state_ff.ack_prio |->
      !STACK_PUSH_OUT ##1 STACK_PUSH_OUT ##1 PC_PUSH_OUT ##1 VEC_LOAD_OUT)
    else $error("low-priority stacking timing wrong");

  brk_vec_a: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    $rose(BUSY_OUT) && ACK_KIND_OUT == KIND_BRK |->
      ##2 VEC_LOAD_OUT && VEC_ADDR_OUT == BRK_VEC)
    else $error("break vector wrong");

  ack_boundary_a: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    ACK_OUT && ACK_KIND_OUT != KIND_BRK |->
      $past(BOUNDARY_IN) && !$past(HOLD_IN))
    else $error("acknowledge outside instruction boundary");

  flag_clear_a: assert property (
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
    ACK_OUT && ACK_KIND_OUT == KIND_MASK |->
      (IRQ_FLAG_OUT & ~$past(set_vec) & (NUM_IRQ'(1) << ack_idx)) == '0)
    else $error("acknowledged request flag not cleared");

endmodule
`default_nettype wire

// ---- cia_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cia_core_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       push_in,
  input  wire logic [7:0] push_data_in,
  input  wire logic       pop_in,
  output var  logic       boundary_out,
  output var  logic       hold_out,
  output var  logic [7:0] top_out
);
  logic [7:0] stk [0:15];
  logic [3:0] sp;
  logic [1:0] cnt;

  // ******************************************************************
  // Instruction stream and status stack of the core
  // ******************************************************************
  initial begin
    boundary_out = 1'b0;
    hold_out     = 1'b0;
  end

  // An instruction ends every third cycle; some are pending-type ones.
  always @(negedge clk_in) begin
    cnt          <= (!rst_n_in || cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
    boundary_out <= rst_n_in && cnt == 2'h2;
    hold_out     <= ($urandom_range(3) == 0);
  end

  // The stack wraps, so unreturned handlers never overflow it.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      sp <= 4'h0;
    end else if (push_in) begin
      stk[sp] <= push_data_in;
      sp      <= sp + 4'h1;
    end else if (pop_in) begin
      sp <= sp - 4'h1;
    end
  end

  assign top_out = stk[sp - 4'h1];
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cia_pkg::*;
  localparam int I_BRK = 0, I_NMI = 1, I_INTERRUPT_RETURN_INSTR = 2, I_BREAK_RETURN_INSTR = 3;
  localparam int I_POP = 4, I_PUSH = 5, I_EI = 6, I_DI = 7;
  logic        clk = 1'b0, rst_n = 1'b0, pin = 1'b0, halt = 1'b0;
  logic        reg_wr = 1'b0, reg_sel = 1'b0, bit_wr = 1'b0, bit_val = 1'b0;
  logic [2:0]  div_n = 3'h0, bit_idx = 3'h0;
  logic [7:0]  wdata = 8'h00, irq_set = 8'h00, mask = 8'hFF, prio = 8'hFF;
  logic [7:0]  ins = 8'h00, sampling_clock_select_reg, program_status_word, flags, stk_data, top, pushed, d;
  logic        busy, ack, stk_push, pc_push, vec_load, bnd, hold;
  logic        acked = 1'b0, pc_prev = 1'b0;
  logic [1:0]  kind;
  logic [15:0] vec;
  logic [25:0] exp_q [$];
  int          miscompares = 0, n_checks = 0, i;

  always #4 clk = ~clk;

  cia_core_model core_u (.clk_in(clk), .rst_n_in(rst_n), .push_in(stk_push),
    .push_data_in(stk_data), .pop_in(|ins[4:2]), .boundary_out(bnd),
    .hold_out(hold), .top_out(top));

  cia_ack_unit #(.NUM_IRQ(8)) dut_u (.CLOCK_IN(clk), .RST_N_IN(rst_n),
    .FILT_PIN_IN(pin), .CPU_DIV_N_IN(div_n), .HALT_IN(halt),
    .IRQ_SET_IN(irq_set), .MASK_IN(mask), .PRIO_IN(prio), .NMI_IN(ins[I_NMI]),
    .BOUNDARY_IN(bnd), .HOLD_IN(hold), .BRK_IN(ins[I_BRK]),
    .INTERRUPT_RETURN_INSTR_IN(ins[I_INTERRUPT_RETURN_INSTR]), .BREAK_RETURN_INSTR_IN(ins[I_BREAK_RETURN_INSTR]), .POP_PSW_IN(ins[I_POP]),
    .PUSH_PSW_IN(ins[I_PUSH]), .EI_IN(ins[I_EI]), .DI_IN(ins[I_DI]),
    .STACK_DATA_IN(top), .REG_WR_IN(reg_wr), .REG_SEL_IN(reg_sel),
    .REG_WDATA_IN(wdata), .BIT_WR_IN(bit_wr), .BIT_IDX_IN(bit_idx),
    .BIT_VAL_IN(bit_val), .SCS_OUT(sampling_clock_select_reg), .PSW_OUT(program_status_word), .IRQ_FLAG_OUT(flags),
    .BUSY_OUT(busy), .ACK_OUT(ack), .ACK_KIND_OUT(kind),
    .STACK_PUSH_OUT(stk_push), .STACK_DATA_OUT(stk_data),
    .PC_PUSH_OUT(pc_push), .VEC_LOAD_OUT(vec_load), .VEC_ADDR_OUT(vec));

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic op(input int b);
    @(negedge clk) ins[b] = 1'b1;
    @(negedge clk) ins = 8'h00;
  endtask
  task automatic wr(input logic sel, input logic [7:0] v);
    @(negedge clk) {reg_sel, wdata, reg_wr} = {sel, v, 1'b1};
    @(negedge clk) reg_wr = 1'b0;
  endtask
  task automatic irq(input logic [7:0] b);
    @(negedge clk) irq_set = b;
    @(negedge clk) irq_set = 8'h00;
  endtask
  task automatic expect_ack(input logic [1:0] k, input logic [15:0] v,
                            input logic [7:0] p);
    exp_q.push_back({k, v, p});
  endtask
  task automatic drain;
    for (int n = 0; n < 100 && exp_q.size() != 0; n++) @(negedge clk);
    chk(32'(exp_q.size()), 32'h0);
    exp_q.delete();
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Every vector load is matched against the oldest expected acknowledge.
  always @(posedge clk) begin
    if (rst_n && stk_push) pushed <= stk_data;
    pc_prev <= pc_push & busy;
    if (rst_n && vec_load) begin
      if (exp_q.size() == 0) chk(32'h0, 32'hFFFFFFFF);
      else chk(32'({kind, vec, pushed}), 32'(exp_q.pop_front()));
      chk(32'({acked, pc_prev, busy}), 32'h6);
      acked <= 1'b0;
    end
    if (rst_n && ack) acked <= 1'b1;
  end

  initial begin
    #(8 * 20000);
    miscompares++;
    wrap_up();
  end

  // ******************************************************************
  // Test sequence
  // ******************************************************************
  initial begin
    void'($urandom(93));
    cyc(4);
    rst_n = 1'b1;
    cyc(1);
    chk(32'(sampling_clock_select_reg), 32'(SCS_RESET_VAL));
    chk(32'(program_status_word), 32'(PSW_RESET_VAL));
    chk(32'(flags), 32'h0);
    d = 8'($urandom);
    wr(REG_SEL_SCS, d);
    chk(32'(sampling_clock_select_reg), 32'(d));
    wr(REG_SEL_PSW, 8'h5A);
    chk(32'(program_status_word), 32'h5A);
    @(negedge clk) {bit_idx, bit_val, bit_wr} = {3'h7, 2'b11};
    @(negedge clk) bit_wr = 1'b0;
    chk(32'(program_status_word), 32'hDA);
    op(I_DI);
    chk(32'(program_status_word), 32'h5A);
    op(I_EI);
    op(I_PUSH);
    wr(REG_SEL_PSW, 8'h00);
    op(I_POP);
    chk(32'(program_status_word), 32'hDA);
    $display("test registers done");
    wr(REG_SEL_SCS, 8'h00);
    halt = 1'b1;
    pin = 1'b1;
    cyc(30);
    chk(32'(flags[0]), 32'h0);
    {pin, halt} = 2'b00;
    wr(REG_SEL_SCS, 8'h01);
    @(negedge clk) pin = 1'b1;
    @(negedge clk) pin = 1'b0;
    cyc(200);
    chk(32'(flags[0]), 32'h0);
    pin = 1'b1;
    cyc(200);
    chk(32'(flags[0]), 32'h1);
    pin = 1'b0;
    prio = 8'hFE;
    expect_ack(2'h1, MASK_VEC_BASE, 8'h82);
    wr(REG_SEL_PSW, 8'h82);
    mask[0] = 1'b0;
    drain();
    chk(32'(flags[0]), 32'h0);
    chk(32'(program_status_word), 32'h00);
    $display("test filter done");
    for (i = 1; i < 8; i++) begin
      prio[i] = 1'($urandom_range(1));
      mask = ~(8'h01 << i);
      expect_ack(2'h1, MASK_VEC_BASE + 16'(2 * i), 8'h82);
      wr(REG_SEL_PSW, 8'h82);
      irq(8'h01 << i);
      drain();
      chk(32'(program_status_word), 32'({6'h00, prio[i], 1'b0}));
    end
    $display("test sources done");
    {prio, mask} = {8'h9F, 8'h08};
    expect_ack(2'h1, 16'h0010, 8'h80);
    wr(REG_SEL_PSW, 8'h80);
    irq(8'h6C);
    drain();
    expect_ack(2'h1, 16'h0012, 8'h80);
    wr(REG_SEL_PSW, 8'h80);
    drain();
    wr(REG_SEL_PSW, 8'h80);
    cyc(40);
    chk(32'(flags), 32'h0C);
    expect_ack(2'h1, 16'h000A, 8'h82);
    wr(REG_SEL_PSW, 8'h82);
    drain();
    cyc(20);
    chk(32'(flags), 32'h08);
    mask = 8'hFF;
    $display("test priority done");
    wr(REG_SEL_PSW, 8'h02);
    expect_ack(2'h0, NMI_VEC, 8'h02);
    op(I_NMI);
    drain();
    chk(32'(program_status_word), 32'h00);
    op(I_NMI);
    op(I_NMI);
    cyc(30);
    expect_ack(2'h0, NMI_VEC, 8'h02);
    op(I_INTERRUPT_RETURN_INSTR);
    drain();
    cyc(30);
    op(I_INTERRUPT_RETURN_INSTR);
    $display("test nmi done");
    wr(REG_SEL_PSW, 8'h82);
    expect_ack(2'h2, BRK_VEC, 8'h82);
    op(I_BRK);
    drain();
    chk(32'(program_status_word), 32'h02);
    op(I_BREAK_RETURN_INSTR);
    chk(32'(program_status_word), 32'h82);
    $display("test break done");
    wrap_up();
  end
endmodule
`default_nettype wire
